//--- logic/fwp_pkg.sv
// Shared constants for the flash write protection block.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
package fwp_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_DATAHI = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SR1    = 8'h14;
  localparam logic [7:0] REG_CR1    = 8'h18;
  localparam logic [7:0] REG_SECT   = 8'h1C;

  // Command codes written to the command register
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h01;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h02;
  localparam logic [7:0] OP_RESET         = 8'h03;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h10;
  localparam logic [7:0] OP_PARAM_ERASE   = 8'h11;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h12;
  localparam logic [7:0] OP_BULK_ERASE    = 8'h13;
  localparam logic [7:0] OP_WRITE_REGS    = 8'h20;
  localparam logic [7:0] OP_WRITE_ANY     = 8'h21;
  localparam logic [7:0] OP_OTP_PROGRAM   = 8'h30;
  localparam logic [7:0] OP_MODE_PROGRAM  = 8'h40;
  localparam logic [7:0] OP_PBIT_PROGRAM  = 8'h41;
  localparam logic [7:0] OP_PBIT_ERASE    = 8'h42;
  localparam logic [7:0] OP_PASS_PROGRAM  = 8'h43;
  localparam logic [7:0] OP_PASS_UNLOCK   = 8'h44;
  localparam logic [7:0] OP_LOCK_CLEAR    = 8'h45;
  localparam logic [7:0] OP_DBIT_WRITE    = 8'h46;
  localparam logic [7:0] OP_LEARN_PROGRAM = 8'h50;
  localparam logic [7:0] OP_CLEAR_STATUS  = 8'h60;

  // Array and OTP geometry
  localparam int         SECTORS      = 256;
  localparam int         SEC_W        = 8;
  localparam int         OTP_REGIONS  = 32;
  localparam int         OTP_ADDR_W   = 10;
  localparam int         OTP_REG_LSB  = 5;
  localparam logic [9:0] OTP_LOCK_LO  = 10'h010;
  localparam logic [9:0] OTP_LOCK_HI  = 10'h013;

  // Register field positions
  localparam int BP_LSB        = 2;
  localparam int STATUS_WRITE_DISABLE_BIT      = 7;
  localparam int CR1_LSB       = 8;
  localparam int FREEZE_BIT    = 0;
  localparam int BOTTOM_BIT    = 5;
  localparam int MODE_LSB      = 1;

  // Protection mode field values
  localparam logic [1:0] MODE_DEFAULT  = 2'h3;
  localparam logic [1:0] MODE_PERSIST  = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL  = 2'h0;

  // Erased states of non-volatile cells
  localparam logic [63:0] PASS_ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [31:0] OTP_LOCK_ERASED = 32'hFFFF_FFFF;

  function automatic logic fwp_needs_wel(input logic [7:0] op);
    return (op == OP_PAGE_PROGRAM) || (op == OP_PARAM_ERASE) ||
           (op == OP_SECTOR_ERASE) || (op == OP_BULK_ERASE) ||
           (op == OP_WRITE_REGS) || (op == OP_WRITE_ANY) ||
           (op == OP_OTP_PROGRAM) || (op == OP_MODE_PROGRAM) ||
           (op == OP_PBIT_PROGRAM) || (op == OP_PBIT_ERASE) ||
           (op == OP_PASS_PROGRAM) || (op == OP_LEARN_PROGRAM);
  endfunction

endpackage

//--- logic/fwp_range_decode.sv
// Block-protect range decode: is one sector inside the protected range.
// Assumes 256 equal sectors numbered from the bottom of the array.
module fwp_range_decode (
  // Protection setting
  input  wire logic [2:0]             bp_i,
  input  wire logic                   bottom_i,
  // Sector under test
  input  wire logic [fwp_pkg::SEC_W-1:0] sector_i,
  output logic                        hit_o
);

  logic [fwp_pkg::SEC_W:0] count;
  logic [fwp_pkg::SEC_W:0] sec_ext;
  logic [fwp_pkg::SEC_W:0] top_start;

  assign count = (bp_i == 3'h0) ? '0 :
                 (bp_i == 3'h7) ? (fwp_pkg::SEC_W + 1)'(fwp_pkg::SECTORS) :
                 (fwp_pkg::SEC_W + 1)'(1) << (bp_i + 3'h1);
  assign sec_ext   = {1'b0, sector_i};
  assign top_start = (fwp_pkg::SEC_W + 1)'(fwp_pkg::SECTORS) - count;
  assign hit_o = bottom_i ? (sec_ext < count) : (sec_ext >= top_start);

endmodule

//--- logic/fwp_sync2.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to mclk_i.
module fwp_sync2 #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

//--- logic/fwp_top.sv
// Write protection logic of a serial NOR flash, reached over APB.
// Assumes the command decoder posts each command through the registers.
// Operation
// - Modifying commands need write enable latch set
// - Latch clears on reset and command completion
// - Block-protect field picks protected array fraction
// - Config bit five anchors range top/bottom
// - Block or sector protection refuses the write
// - Freeze holds block-protect bits and OTP
// - Low write-protect pin plus disable bit locks
// - Persistent or dynamic bit zero protects sector
// - Lock bit zero refuses persistent bit changes
// - Persistent mode: lock set at reset
// - Persistent mode: command clears lock only
// - Password mode: lock cleared at reset
// - Exact password match sets the lock
// - Password mode: command clears lock again
// - Mode register programmable only once
// - Each lock bit guards one OTP region
// - Lowest lock bit guards lock bytes too
// - Frozen OTP program fails, out-of-range ignored
// - Dynamic bit written either way freely
// - Mode field encodings; both zero fails
//
// Chosen here: the placing of the registers and register access over APB.
module fwp_top #(
  parameter logic DYN_RESET = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Pins
  input  wire logic        hw_reset_n_i,
  input  wire logic        write_protect_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Verdict towards the array sequencer
  output logic             op_grant_o,
  output logic             op_refuse_o,
  output logic [7:0]       op_code_o,
  output logic [31:0]      op_addr_o
);

  logic                    wp_n_s;
  logic                    hw_rst_n_s;
  logic [31:0]             addr_r;
  logic [31:0]             data_r;
  logic [31:0]             datahi_r;
  logic                    wel_r;
  logic                    perr_r;
  logic                    lock_r;
  logic                    freeze_r;
  logic [2:0]              bp_r;
  logic                    status_write_disable_r;
  logic                    bottom_r;
  logic [1:0]              mode_r;
  logic [63:0]             pass_r;
  logic [31:0]             otp_lock_r;
  logic [fwp_pkg::SECTORS-1:0] pbit_r;
  logic [fwp_pkg::SECTORS-1:0] dbit_r;
  logic                    grant_r;
  logic                    refuse_r;
  logic [7:0]              code_r;
  logic [31:0]             oaddr_r;
  logic [31:0]             prdata_r;
  logic                    slverr_r;

  fwp_sync2 #(.INIT(1'b1)) u_wp_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (write_protect_n_i),
    .sync_o  (wp_n_s)
  );

  fwp_sync2 #(.INIT(1'b1)) u_rst_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (hw_reset_n_i),
    .sync_o  (hw_rst_n_s)
  );

  // Bus decode
  wire        apb_setup = psel_i & ~penable_i;
  wire        apb_wr    = psel_i & penable_i & pwrite_i;
  wire        addr_ok   = (paddr_i[1:0] == 2'h0) && (paddr_i <= fwp_pkg::REG_SECT);
  wire        cmd_wr    = apb_wr & addr_ok & (paddr_i == fwp_pkg::REG_CMD);
  wire [7:0]  opc       = pwdata_i[7:0];
  wire        hw_rst    = ~hw_rst_n_s;

  // Protection evaluation
  wire [fwp_pkg::SEC_W-1:0] sec = addr_r[fwp_pkg::SEC_W-1:0];
  logic bp_hit;

  fwp_range_decode u_range (
    .bp_i     (bp_r),
    .bottom_i (bottom_r),
    .sector_i (sec),
    .hit_o    (bp_hit)
  );

  wire sec_asp_prot = ~pbit_r[sec] | ~dbit_r[sec];
  wire sec_prot     = bp_hit | sec_asp_prot;
  wire any_prot     = (bp_r != 3'h0) | ~(&pbit_r) | ~(&dbit_r);
  // pin low and disable bit set
  wire reg_locked   = ~wp_n_s & status_write_disable_r;
  wire mode_set     = (mode_r != fwp_pkg::MODE_DEFAULT);
  wire is_password  = (mode_r == fwp_pkg::MODE_PASSWORD);

  wire [fwp_pkg::OTP_ADDR_W-1:0] otp_addr = addr_r[fwp_pkg::OTP_ADDR_W-1:0];
  wire [4:0] otp_region = otp_addr[fwp_pkg::OTP_ADDR_W-1:fwp_pkg::OTP_REG_LSB];
  wire       otp_valid  = (addr_r[31:fwp_pkg::OTP_ADDR_W] == '0);
  wire       otp_locked = ~otp_lock_r[otp_region];
  wire       otp_is_lock = (otp_addr >= fwp_pkg::OTP_LOCK_LO) &&
                           (otp_addr <= fwp_pkg::OTP_LOCK_HI);
  wire [7:0] wr_sr1     = data_r[7:0];
  wire [7:0] wr_cr1     = data_r[fwp_pkg::CR1_LSB +: 8];
  wire [1:0] new_mode   = data_r[fwp_pkg::MODE_LSB +: 2];
  wire       pass_match = ({datahi_r, data_r} == pass_r);

  wire need_wel = fwp_pkg::fwp_needs_wel(opc);
  wire wel_miss = need_wel & ~wel_r;

  logic cmd_fail;
  logic cmd_ignore;

  always_comb begin
    cmd_fail   = 1'b0;
    cmd_ignore = 1'b0;
    unique case (opc)
      fwp_pkg::OP_PAGE_PROGRAM,
      fwp_pkg::OP_PARAM_ERASE,
      fwp_pkg::OP_SECTOR_ERASE: begin
        cmd_fail = sec_prot;
      end
      fwp_pkg::OP_BULK_ERASE: begin
        cmd_fail = any_prot;
      end
      fwp_pkg::OP_WRITE_REGS,
      fwp_pkg::OP_WRITE_ANY: begin
        cmd_fail = reg_locked |
                   (mode_set & (wr_cr1[fwp_pkg::BOTTOM_BIT] != bottom_r));
      end
      fwp_pkg::OP_OTP_PROGRAM: begin
        cmd_ignore = ~otp_valid;
        cmd_fail   = otp_valid & (freeze_r | otp_locked);
      end
      fwp_pkg::OP_MODE_PROGRAM: begin
        cmd_fail = mode_set | (new_mode == fwp_pkg::MODE_ILLEGAL);
      end
      fwp_pkg::OP_PBIT_PROGRAM,
      fwp_pkg::OP_PBIT_ERASE: begin
        cmd_fail = ~lock_r;
      end
      fwp_pkg::OP_PASS_PROGRAM,
      fwp_pkg::OP_LEARN_PROGRAM: begin
        cmd_fail = mode_set;
      end
      fwp_pkg::OP_PASS_UNLOCK: begin
        cmd_fail = ~is_password | ~pass_match;
      end
      default: begin
        cmd_fail   = 1'b0;
        cmd_ignore = 1'b0;
      end
    endcase
  end

  wire cmd_ok   = cmd_wr & ~wel_miss & ~cmd_fail & ~cmd_ignore;
  wire cmd_bad  = cmd_wr & ~wel_miss & cmd_fail;
  wire cmd_done = cmd_wr & (need_wel | (opc == fwp_pkg::OP_WRITE_DISABLE) |
                            (opc == fwp_pkg::OP_RESET));
  wire do_op    = cmd_ok & (opc == fwp_pkg::OP_OTP_PROGRAM ? 1'b1 : 1'b1);

  // Settings registers and latch
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wel_r    <= 1'b0;
      perr_r   <= 1'b0;
      freeze_r <= 1'b0;
      bp_r     <= 3'h0;
      status_write_disable_r   <= 1'b0;
      bottom_r <= 1'b0;
      mode_r   <= fwp_pkg::MODE_DEFAULT;
      pass_r   <= fwp_pkg::PASS_ERASED;
      otp_lock_r <= fwp_pkg::OTP_LOCK_ERASED;
    end else if (hw_rst) begin
      wel_r  <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      if (cmd_wr && opc == fwp_pkg::OP_WRITE_ENABLE) begin
        wel_r <= 1'b1;
      end else if (cmd_done) begin
        wel_r <= 1'b0;
      end
      if (cmd_bad) begin
        perr_r <= 1'b1;
      end else if (cmd_wr && opc == fwp_pkg::OP_CLEAR_STATUS) begin
        perr_r <= 1'b0;
      end
      if (cmd_ok && (opc == fwp_pkg::OP_WRITE_REGS || opc == fwp_pkg::OP_WRITE_ANY)) begin
        if (!freeze_r) begin
          bp_r     <= wr_sr1[fwp_pkg::BP_LSB +: 3];
          bottom_r <= wr_cr1[fwp_pkg::BOTTOM_BIT];
        end
        status_write_disable_r   <= wr_sr1[fwp_pkg::STATUS_WRITE_DISABLE_BIT];
        freeze_r <= freeze_r | wr_cr1[fwp_pkg::FREEZE_BIT];
      end
      if (cmd_ok && opc == fwp_pkg::OP_MODE_PROGRAM) begin
        mode_r <= new_mode;
      end
      if (cmd_ok && opc == fwp_pkg::OP_PASS_PROGRAM) begin
        pass_r <= pass_r & {datahi_r, data_r};
      end
      if (cmd_ok && opc == fwp_pkg::OP_OTP_PROGRAM && otp_is_lock) begin
        otp_lock_r[otp_addr[1:0]*8 +: 8] <= otp_lock_r[otp_addr[1:0]*8 +: 8] & data_r[7:0];
      end
    end
  end

  // Sector bits and lock bit
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pbit_r <= '1;
      dbit_r <= {fwp_pkg::SECTORS{DYN_RESET}};
      lock_r <= 1'b1;
    end else if (hw_rst) begin
      dbit_r <= {fwp_pkg::SECTORS{DYN_RESET}};
      lock_r <= ~is_password;
    end else begin
      if (cmd_ok && opc == fwp_pkg::OP_PBIT_PROGRAM) begin
        pbit_r[sec] <= 1'b0;
      end else if (cmd_ok && opc == fwp_pkg::OP_PBIT_ERASE) begin
        pbit_r <= '1;
      end
      if (cmd_wr && opc == fwp_pkg::OP_DBIT_WRITE) begin
        dbit_r[sec] <= data_r[0];
      end
      if (cmd_wr && opc == fwp_pkg::OP_LOCK_CLEAR) begin
        lock_r <= 1'b0;
      end else if (cmd_ok && opc == fwp_pkg::OP_PASS_UNLOCK) begin
        lock_r <= 1'b1;
      end
    end
  end

  // Operand registers and verdict
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      addr_r   <= '0;
      data_r   <= '0;
      datahi_r <= '0;
      grant_r  <= 1'b0;
      refuse_r <= 1'b0;
      code_r   <= '0;
      oaddr_r  <= '0;
    end else begin
      if (apb_wr && paddr_i == fwp_pkg::REG_ADDR) begin
        addr_r <= pwdata_i;
      end
      if (apb_wr && paddr_i == fwp_pkg::REG_DATA) begin
        data_r <= pwdata_i;
      end
      if (apb_wr && paddr_i == fwp_pkg::REG_DATAHI) begin
        datahi_r <= pwdata_i;
      end
      grant_r  <= do_op & need_wel;
      refuse_r <= cmd_wr & need_wel & ~do_op;
      if (cmd_wr && need_wel) begin
        code_r  <= opc;
        oaddr_r <= addr_r;
      end
    end
  end

  // Read mux
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (paddr_i)
      fwp_pkg::REG_ADDR:   rd_mux = addr_r;
      fwp_pkg::REG_DATA:   rd_mux = data_r;
      fwp_pkg::REG_DATAHI: rd_mux = datahi_r;
      fwp_pkg::REG_STATUS: rd_mux = {24'h0, refuse_r, grant_r, mode_r,
                                     freeze_r, lock_r, perr_r, wel_r};
      fwp_pkg::REG_SR1:    rd_mux = {24'h0, status_write_disable_r, 2'h0, bp_r, 2'h0};
      fwp_pkg::REG_CR1:    rd_mux = {26'h0, bottom_r, 4'h0, freeze_r};
      fwp_pkg::REG_SECT:   rd_mux = {28'h0, sec_prot, bp_hit, dbit_r[sec], pbit_r[sec]};
      default:             rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= addr_ok ? rd_mux : 32'h0000_0000;
      slverr_r <= ~addr_ok;
    end
  end

  assign prdata_o    = prdata_r;
  assign pready_o    = 1'b1;
  assign pslverr_o   = slverr_r & psel_i & penable_i;
  assign op_grant_o  = grant_r;
  assign op_refuse_o = refuse_r;
  assign op_code_o   = code_r;
  assign op_addr_o   = oaddr_r;

endmodule

//--- testbench/fwp_host.sv
// Host model: APB master that posts commands to the protection block.
// Assumes callers run one transfer at a time from one process.
module fwp_host (
  // Clock
  input  wire logic        mclk_i,
  // APB master
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    do @(posedge mclk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    // Released bus shows inverted values, not the last ones
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic mod(input logic [7:0] op, input logic [31:0] a, input logic [31:0] d);
    wr(fwp_pkg::REG_ADDR, a);
    wr(fwp_pkg::REG_DATA, d);
    wr(fwp_pkg::REG_CMD, 32'(fwp_pkg::OP_WRITE_ENABLE));
    wr(fwp_pkg::REG_CMD, 32'(op));
  endtask
endmodule

//--- testbench/fwp_top_assertions.sv
// Checker for the flash write protection block, watching only its ports.
// Assumes modifying commands are posted through the command register.
module fwp_top_assertions (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Pins
  input  wire logic        hw_reset_n_i,
  input  wire logic        write_protect_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // Verdict
  input  wire logic        op_grant_o,
  input  wire logic        op_refuse_o,
  input  wire logic [7:0]  op_code_o,
  input  wire logic [31:0] op_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]  hw_hist_r;
  logic        wel_m_r;
  logic [31:0] addr_m_r;
  wire         apb_wr   = psel_i && penable_i && pwrite_i && pready_o;
  wire         cmd_wr   = apb_wr && (paddr_i == fwp_pkg::REG_CMD);
  wire [7:0]   op       = pwdata_i[7:0];
  wire         is_mod   = op inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21,
                                     8'h30, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50};
  // Commands while the reset pin or its synchroniser is active are ignored
  wire         hw_ok    = hw_reset_n_i && (&hw_hist_r);
  wire         cmd_mod  = cmd_wr && is_mod && hw_ok;
  wire         wel_nxt  = (reset_i || !hw_ok) ? 1'b0 :
                          (cmd_wr && op == 8'h01) ? 1'b1 :
                          (cmd_wr && (is_mod || op == 8'h02 || op == 8'h03)) ? 1'b0 : wel_m_r;
  wire [31:0]  addr_nxt = (apb_wr && paddr_i == fwp_pkg::REG_ADDR) ? pwdata_i : addr_m_r;

  always_ff @(posedge mclk_i) begin
    hw_hist_r <= reset_i ? 3'h7 : {hw_hist_r[1:0], hw_reset_n_i};
    wel_m_r   <= wel_nxt;
    addr_m_r  <= reset_i ? 32'h0 : addr_nxt;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_VERDICT_ONE: assert property (cmd_mod |-> ##1 (op_grant_o ^ op_refuse_o))
    else $error("modifying command gave no single verdict");
  AST_WEL_NEEDED: assert property (cmd_mod && !wel_m_r |-> ##1 op_refuse_o)
    else $error("modifying command without write enable not refused");
  AST_CODE_ECHO: assert property (cmd_mod |-> ##1 (op_code_o == $past(pwdata_i[7:0])))
    else $error("verdict opcode differs from command");
  AST_ADDR_ECHO: assert property (cmd_mod |-> ##1 (op_addr_o == addr_m_r))
    else $error("verdict address differs from address register");
  AST_NO_VERDICT: assert property (cmd_wr && !is_mod |-> ##1 !(op_grant_o || op_refuse_o))
    else $error("non-modifying command gave a verdict");
  AST_CAUSE: assert property ((op_grant_o || op_refuse_o) |-> $past(cmd_wr && is_mod))
    else $error("verdict without a modifying command");
  AST_CODE_HOLD: assert property (!(op_grant_o || op_refuse_o) |-> $stable(op_code_o))
    else $error("verdict opcode changed without a verdict");
  AST_PULSE_SINGLE: assert property ((op_grant_o || op_refuse_o) |=> !op_grant_o && !op_refuse_o)
    else $error("verdict pulse longer than one cycle");
endmodule

bind fwp_top fwp_top_assertions i_fwp_top_assertions (
  .mclk_i(mclk_i), .reset_i(reset_i), .hw_reset_n_i(hw_reset_n_i),
  .write_protect_n_i(write_protect_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .op_grant_o(op_grant_o),
  .op_refuse_o(op_refuse_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o)
);

//--- testbench/fwp_top_tb_top.sv
// Self-checking bench for the flash write protection block.
// Assumes the host model drives APB and this module drives the pins.
module fwp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i, reset_i, hw_reset_n_i, write_protect_n_i;
  logic        psel, penable, pwrite, pready, op_grant, op_refuse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          n_errors, comparisons, cycles = 0;

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  fwp_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .hw_reset_n_i(hw_reset_n_i),
    .write_protect_n_i(write_protect_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(), .op_grant_o(op_grant), .op_refuse_o(op_refuse),
    .op_code_o(), .op_addr_o());
  fwp_host i_host (.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready));

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chkv(input logic e);
    logic [1:0] v;
    v = 2'b00;
    for (int i = 0; i < 4 && v === 2'b00; i++) begin
      @(negedge mclk_i);
      v = {op_grant, op_refuse};
    end
    chk(32'(v), e ? 32'h2 : 32'h1);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic st(input logic [31:0] e);
    rdm(fwp_pkg::REG_STATUS, 32'h3F, e);
  endtask

  task automatic sect(input int s, input logic [31:0] m, input logic [31:0] e);
    i_host.wr(fwp_pkg::REG_ADDR, 32'(s));
    rdm(fwp_pkg::REG_SECT, m, e);
  endtask

  task automatic cmdn(input logic [7:0] op, input logic [31:0] d);
    i_host.wr(fwp_pkg::REG_DATA, d);
    i_host.wr(fwp_pkg::REG_CMD, 32'(op));
  endtask

  task automatic hwr();
    @(posedge mclk_i);
    hw_reset_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    hw_reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask

  function automatic int nprot(input int v);
    return (v == 0) ? 0 : (v == 7) ? 256 : (4 << (v - 1));
  endfunction

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    int s;
    int n;
    reset_i = 1'b1;
    hw_reset_n_i = 1'b1;
    write_protect_n_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    st(32'h34);  // lock set
    i_host.wr(fwp_pkg::REG_ADDR, 32'h5);
    cmdn(fwp_pkg::OP_SECTOR_ERASE, 32'h0);
    chkv(1'b0);  // no latch
    cmdn(fwp_pkg::OP_WRITE_ENABLE, 32'h0);
    st(32'h35);  // latch set
    cmdn(fwp_pkg::OP_WRITE_DISABLE, 32'h0);
    st(32'h34);  // disable clears
    cmdn(fwp_pkg::OP_WRITE_ENABLE, 32'h0);
    cmdn(fwp_pkg::OP_RESET, 32'h0);
    st(32'h34);  // reset clears
    i_host.mod(fwp_pkg::OP_SECTOR_ERASE, 32'h5, 32'h0);
    chkv(1'b1);  // granted
    st(32'h34);  // completion clears
    for (int b = 0; b < 2; b++) begin
      for (int v = 0; v < 8; v++) begin
        n = nprot(v);
        i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'((b << 13) | (v << 2)));
        chkv(1'b1);  // accepted
        for (int k = 0; k < 4; k++) begin
          s = (k == 0) ? n % 256 : (k == 1) ? (n + 255) % 256 : (k == 2) ? (256 - n) % 256
              : (511 - n) % 256;
          sect(s, 32'hC, ((b == 1) ? (s < n) : (s >= 256 - n)) ? 32'hC : 32'h0);  // range
        end
      end
    end
    i_host.mod(fwp_pkg::OP_SECTOR_ERASE, 32'd100, 32'h0);
    chkv(1'b0);  // block range
    st(32'h36);  // error flag
    cmdn(fwp_pkg::OP_CLEAR_STATUS, 32'h0);
    i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'h0);
    chkv(1'b1);  // cleared
    i_host.wr(fwp_pkg::REG_ADDR, 32'h9);
    cmdn(fwp_pkg::OP_DBIT_WRITE, 32'h0);
    sect(9, 32'hF, 32'h9);  // cleared
    i_host.mod(fwp_pkg::OP_PAGE_PROGRAM, 32'h9, 32'h0);
    chkv(1'b0);  // dynamic
    cmdn(fwp_pkg::OP_DBIT_WRITE, 32'h1);
    sect(9, 32'hF, 32'h3);  // set
    i_host.mod(fwp_pkg::OP_PAGE_PROGRAM, 32'h9, 32'h0);
    chkv(1'b1);  // unprotected
    i_host.mod(fwp_pkg::OP_PBIT_PROGRAM, 32'd20, 32'h0);
    chkv(1'b1);  // lock open
    sect(20, 32'hF, 32'hA);  // persistent
    cmdn(fwp_pkg::OP_LOCK_CLEAR, 32'h0);
    st(32'h32);  // lock cleared
    i_host.mod(fwp_pkg::OP_PBIT_ERASE, 32'd20, 32'h0);
    chkv(1'b0);  // locked
    cmdn(fwp_pkg::OP_WRITE_ENABLE, 32'h0);
    hwr();
    st(32'h34);  // pin reset
    i_host.mod(fwp_pkg::OP_PBIT_ERASE, 32'd20, 32'h0);
    chkv(1'b1);  // lock reopened
    sect(20, 32'hF, 32'h3);  // erased
    i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'h80);
    chkv(1'b1);  // disable bit set
    @(posedge mclk_i);
    write_protect_n_i <= 1'b0;
    i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'h0);
    chkv(1'b0);  // pin locks
    rdm(fwp_pkg::REG_SR1, 32'hFF, 32'h80);  // bits kept
    @(posedge mclk_i);
    write_protect_n_i <= 1'b1;
    i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'h0);
    chkv(1'b1);  // pin released
    cmdn(fwp_pkg::OP_CLEAR_STATUS, 32'h0);
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h400, 32'h0);
    chkv(1'b0);  // outside ignored
    st(32'h34);  // no error flag
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h10, 32'hFD);
    chkv(1'b1);  // lock region 1
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h20, 32'h0);
    chkv(1'b0);  // region 1 locked
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h40, 32'h0);
    chkv(1'b1);  // region 2 open
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h10, 32'hFE);
    chkv(1'b1);  // lock region 0
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h11, 32'hFF);
    chkv(1'b0);  // lock bytes locked
    i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'h104);
    chkv(1'b1);  // freeze set
    i_host.mod(fwp_pkg::OP_WRITE_REGS, 32'h0, 32'h8);
    chkv(1'b1);  // silently kept
    rdm(fwp_pkg::REG_SR1, 32'h1C, 32'h4);  // field held
    cmdn(fwp_pkg::OP_CLEAR_STATUS, 32'h0);
    i_host.mod(fwp_pkg::OP_OTP_PROGRAM, 32'h40, 32'h0);
    chkv(1'b0);  // frozen
    st(32'h3E);  // error flag
    i_host.mod(fwp_pkg::OP_MODE_PROGRAM, 32'h0, 32'h0);
    chkv(1'b0);  // both zero
    i_host.mod(fwp_pkg::OP_PASS_PROGRAM, 32'h0, 32'h1234_5678);
    chkv(1'b1);  // password stored
    i_host.mod(fwp_pkg::OP_MODE_PROGRAM, 32'h0, 32'h2);
    chkv(1'b1);  // password mode
    i_host.mod(fwp_pkg::OP_MODE_PROGRAM, 32'h0, 32'h4);
    chkv(1'b0);  // mode fixed
    hwr();
    st(32'h18);  // lock cleared
    cmdn(fwp_pkg::OP_PASS_UNLOCK, 32'h1234_5679);
    st(32'h1A);  // wrong password
    cmdn(fwp_pkg::OP_PASS_UNLOCK, 32'h1234_5678);
    st(32'h1E);  // exact match
    cmdn(fwp_pkg::OP_LOCK_CLEAR, 32'h0);
    st(32'h1A);  // cleared again
    end_sim();
  end
endmodule
